/* File: hw/pie_top.sv */
// Notes on behaviour
// - enable two bit 4 passes the nvm write done interrupt
// - enable two bit 3 passes the serial bus collision interrupt
// - enable two bit 2 passes the fourth comparator interrupt
// - enable two bit 1 passes the third comparator interrupt
// - enable two bit 0 passes the second capture unit interrupt
// - the peripheral request needs the peripheral master enable; the status interrupt on IRQ_OUT does not
// - enable three bit 4 is read/write and passes third capture unit
// - other enable three bits ignore writes and read zero
// - every enable bit clears to zero on any reset
// - pending flags set on events regardless of enables
//
// peripheral interrupt enable gating with apb registers
// assumes apb master on the core clock, events one-cycle pulses
`timescale 1ns/1ps
module pie_top
   import pie_pkg::*;
(
   // clock, reset, enable
   input  wire logic                 CORE_CLK_IN,
   input  wire logic                 RST_B_IN,
   input  wire logic                 CLK_EN_IN,
   // apb slave
   input  wire logic                 PSEL_IN,
   input  wire logic                 PENABLE_IN,
   input  wire logic                 PWRITE_IN,
   input  wire logic [7:0]           PADDR_IN,
   input  wire logic [31:0]          PWDATA_IN,
   output logic      [31:0]          PRDATA_OUT,
   output logic                      PREADY_OUT,
   output logic                      PSLVERR_OUT,
   // peripheral events
   input  wire logic [NUM_SRC-1:0]   EVENT_IN,
   // processor side
   output logic                      PERIPH_IRQ_OUT,
   output logic                      IRQ_OUT
);
   import pie_pkg::*;

   logic [7:0]         en_two_q,  en_two_d;
   logic [7:0]         en_three_q, en_three_d;
   logic               master_q,  master_d;
   logic [NUM_EV-1:0]  stat_q,    stat_d;
   logic [NUM_EV-1:0]  mask_q,    mask_d;
   logic [31:0]        rdata_q,   rdata_d;
   logic               ready_q,   ready_d;
   logic               err_q,     err_d;
   logic               preq_q,    preq_d;
   logic               irq_q,     irq_d;
   logic               evseen_q,  evseen_d;
   logic [NUM_SRC-1:0] flag_clr;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] flags;
   logic [NUM_SRC-1:0] gated;
   logic               wr_acc;
   logic               rd_acc;
   logic               req_now;

   // access is taken in the cycle before pready, answered with one wait
   assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & ~ready_q;
   assign rd_acc = PSEL_IN & PENABLE_IN & ~PWRITE_IN & ~ready_q;

   // per-source enable selection in flag order
   always_comb begin
      src_en[0]                = en_two_q[NVM_DONE_BIT];
      src_en[1]                = en_two_q[SER_COLL_BIT];
      src_en[2]                = en_two_q[CMP_FOUR_BIT];
      src_en[3]                = en_two_q[CMP_THREE_BIT];
      src_en[4]                = en_two_q[CAPCMP_TWO_BIT];
      src_en[SRC_CAPCMP_THREE] = en_three_q[CAPCMP_THREE_BIT];
   end

   // pending flags, one per source
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_flag
         pie_flag u_flag (
            .clk_in    (CORE_CLK_IN),
            .rst_b_in  (RST_B_IN),
            .ce_in     (CLK_EN_IN),
            .set_in    (EVENT_IN[g]),
            .clr_in    (flag_clr[g]),
            .en_in     (src_en[g]),
            .flag_out  (flags[g]),
            .gated_out (gated[g])
         );
      end
   endgenerate

   // gated request to the processor
   assign req_now = master_q & (|gated);

   // register writes and read mux
   always_comb begin
      en_two_d   = en_two_q;
      en_three_d = en_three_q;
      master_d   = master_q;
      mask_d     = mask_q;
      flag_clr   = '0;
      rdata_d    = rdata_q;
      err_d      = 1'b0;
      ready_d    = wr_acc | rd_acc;
      stat_d     = stat_q;
      if (wr_acc) begin
         if (PADDR_IN == ENABLE_TWO_OFS) begin
            en_two_d[NVM_DONE_BIT:CAPCMP_TWO_BIT] = PWDATA_IN[NVM_DONE_BIT:CAPCMP_TWO_BIT];
         end else if (PADDR_IN == ENABLE_THREE_OFS) begin
            en_three_d[CAPCMP_THREE_BIT] = PWDATA_IN[CAPCMP_THREE_BIT];
         end else if (PADDR_IN == CORE_CTRL_OFS) begin
            master_d = PWDATA_IN[MASTER_EN_BIT];
         end else if (PADDR_IN == FLAG_OFS) begin
            flag_clr = PWDATA_IN[NUM_SRC-1:0];
         end else if (PADDR_IN == STATUS_OFS) begin
            stat_d = stat_q & ~PWDATA_IN[NUM_EV-1:0];
         end else if (PADDR_IN == MASK_OFS) begin
            mask_d = PWDATA_IN[NUM_EV-1:0];
         end else begin
            // refused write answers with zero data as well as the error
            err_d   = 1'b1;
            rdata_d = ZERO_WORD;
         end
      end
      if (rd_acc) begin
         rdata_d = ZERO_WORD;
         if (PADDR_IN == ENABLE_TWO_OFS) begin
            rdata_d[7:0] = en_two_q;
         end else if (PADDR_IN == ENABLE_THREE_OFS) begin
            rdata_d[7:0] = en_three_q;
         end else if (PADDR_IN == CORE_CTRL_OFS) begin
            rdata_d[MASTER_EN_BIT] = master_q;
         end else if (PADDR_IN == FLAG_OFS) begin
            rdata_d[NUM_SRC-1:0] = flags;
         end else if (PADDR_IN == STATUS_OFS) begin
            rdata_d[NUM_EV-1:0] = stat_q;
         end else if (PADDR_IN == MASK_OFS) begin
            rdata_d[NUM_EV-1:0] = mask_q;
         end else begin
            err_d = 1'b1;
         end
      end
      // sticky events, set wins over a clear in the same cycle
      evseen_d = |EVENT_IN;
      preq_d   = req_now;
      if (req_now & ~preq_q) begin
         stat_d[EV_REQ_RISE] = 1'b1;
      end
      if (evseen_q) begin
         stat_d[EV_FLAG_SET] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
   end

   // state registers, all enables clear on reset
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         en_two_q   <= ENABLE_RESET;
         en_three_q <= ENABLE_RESET;
         master_q   <= 1'b0;
         stat_q     <= '0;
         mask_q     <= '0;
         rdata_q    <= ZERO_WORD;
         ready_q    <= 1'b0;
         err_q      <= 1'b0;
         preq_q     <= 1'b0;
         irq_q      <= 1'b0;
         evseen_q   <= 1'b0;
      end else if (CLK_EN_IN) begin
         en_two_q   <= en_two_d;
         en_three_q <= en_three_d;
         master_q   <= master_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
         rdata_q    <= rdata_d;
         ready_q    <= ready_d;
         err_q      <= err_d;
         preq_q     <= preq_d;
         irq_q      <= irq_d;
         evseen_q   <= evseen_d;
      end
   end

   // outputs straight from flip-flops
   assign PRDATA_OUT     = rdata_q;
   assign PREADY_OUT     = ready_q;
   assign PSLVERR_OUT    = err_q;
   assign PERIPH_IRQ_OUT = preq_q;
   assign IRQ_OUT        = irq_q;
endmodule

/* File: hw/pie_pkg.sv */
// package for the peripheral interrupt enable gating block
// assumes a 32-bit apb register bus on the core clock
package pie_pkg;
   // register byte offsets
   localparam logic [7:0] ENABLE_TWO_OFS   = 8'h00;
   localparam logic [7:0] ENABLE_THREE_OFS = 8'h04;
   localparam logic [7:0] CORE_CTRL_OFS    = 8'h08;
   localparam logic [7:0] FLAG_OFS         = 8'h0C;
   localparam logic [7:0] STATUS_OFS       = 8'h10;
   localparam logic [7:0] MASK_OFS         = 8'h14;
   // enable two field positions
   localparam int NVM_DONE_BIT   = 4;
   localparam int SER_COLL_BIT   = 3;
   localparam int CMP_FOUR_BIT   = 2;
   localparam int CMP_THREE_BIT  = 1;
   localparam int CAPCMP_TWO_BIT = 0;
   // enable three and core control field positions
   localparam int CAPCMP_THREE_BIT = 4;
   localparam int MASTER_EN_BIT    = 6;
   // source count and source index of the third capture unit
   localparam int NUM_SRC        = 6;
   localparam int SRC_CAPCMP_THREE = 5;
   // reset values
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
   // interrupt status bit positions
   localparam int EV_REQ_RISE = 0;
   localparam int EV_FLAG_SET = 1;
   localparam int NUM_EV      = 2;
endpackage

/* File: hw/pie_flag.sv */
// one pending flag with set, write-one-to-clear and enable gating
// assumes events are synchronous to the core clock
`timescale 1ns/1ps
module pie_flag (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic ce_in,
   // flag control
   input  wire logic set_in,
   input  wire logic clr_in,
   input  wire logic en_in,
   // results
   output logic      flag_out,
   output logic      gated_out
);
   logic flag_q;
   logic flag_d;

   // set wins over clear
   always_comb begin
      flag_d = flag_q;
      if (clr_in) begin
         flag_d = 1'b0;
      end
      if (set_in) begin
         flag_d = 1'b1;
      end
   end

   // flag register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_q <= 1'b0;
      end else if (ce_in) begin
         flag_q <= flag_d;
      end
   end

   assign flag_out  = flag_q;
   assign gated_out = flag_q & en_in;
endmodule

/* File: sim/pie_src_model.sv */
// peripheral event sources facing the gating block
// assumes the bench raises a request bit for one cycle
`timescale 1ns/1ps
module pie_src_model
   import pie_pkg::*;
(
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_b_in,
   // bench request and condition pulses
   input  wire logic [NUM_SRC-1:0] req_in,
   output logic      [NUM_SRC-1:0] ev_out
);
   logic [NUM_SRC-1:0] ev_q;
   logic [NUM_SRC-1:0] ev_d;
   // a request turns into a one-cycle condition pulse
   always_comb ev_d = req_in & ~ev_q;
   always_ff @(posedge clk_in or negedge rst_b_in)
      if (!rst_b_in) ev_q <= '0; else ev_q <= ev_d;
   assign ev_out = ev_q;
endmodule

/* File: sim/pie_properties.sv */
// assertions on the gating block ports
// assumes writes land before the ready pulse
`timescale 1ns/1ps
module pie_chk
   import pie_pkg::*;
(
   input  wire logic               CORE_CLK_IN,
   input  wire logic               RST_B_IN,
   input  wire logic               PSEL_IN,
   input  wire logic               PENABLE_IN,
   input  wire logic               PWRITE_IN,
   input  wire logic [7:0]         PADDR_IN,
   input  wire logic [31:0]        PWDATA_IN,
   input  wire logic [31:0]        PRDATA_OUT,
   input  wire logic               PREADY_OUT,
   input  wire logic               PSLVERR_OUT,
   input  wire logic [NUM_SRC-1:0] EVENT_IN,
   input  wire logic               PERIPH_IRQ_OUT,
   input  wire logic               IRQ_OUT
);
   logic [6:0] sh_q;
   logic [6:0] sh_d;
   logic       wr;
   logic [5:0] en;
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // shadow of master and enables from finished writes
   assign wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
   always_comb begin
      sh_d = sh_q;
      if (wr && PADDR_IN == ENABLE_TWO_OFS) sh_d[4:0] = PWDATA_IN[4:0];
      if (wr && PADDR_IN == ENABLE_THREE_OFS) sh_d[5] = PWDATA_IN[4];
      if (wr && PADDR_IN == CORE_CTRL_OFS) sh_d[6] = PWDATA_IN[6];
   end
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
      if (!RST_B_IN) sh_q <= '0; else sh_q <= sh_d;
   // source order of the enables
   assign en = {sh_q[5], sh_q[0], sh_q[1], sh_q[2], sh_q[3], sh_q[4]};
   property p_lat; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT; endproperty
   a_lat: assert property (p_lat) else $error("ready timing wrong");
   property p_rst; $rose(RST_B_IN) |-> !PERIPH_IRQ_OUT && !IRQ_OUT && !PREADY_OUT; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   property p_rd2; PREADY_OUT && !PWRITE_IN && PADDR_IN == ENABLE_TWO_OFS
      |-> PRDATA_OUT == {27'h000_0000, sh_q[4:0]}; endproperty
   a_rd2: assert property (p_rd2) else $error("enable two read wrong");
   property p_rd3; PREADY_OUT && !PWRITE_IN && PADDR_IN == ENABLE_THREE_OFS
      |-> PRDATA_OUT == {27'h000_0000, sh_q[5], 4'h0}; endproperty
   a_rd3: assert property (p_rd3) else $error("enable three read wrong");
   property p_off; !sh_q[6] |-> !PERIPH_IRQ_OUT; endproperty
   a_off: assert property (p_off) else $error("request without master");
   property p_gate; en == 6'h00 |-> !PERIPH_IRQ_OUT; endproperty
   a_gate: assert property (p_gate) else $error("request without enable");
   property p_ev; (|(EVENT_IN & en)) && sh_q[6] |-> ##2 PERIPH_IRQ_OUT; endproperty
   a_ev: assert property (p_ev) else $error("enabled event lost");
   property p_err; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == ZERO_WORD; endproperty
   a_err: assert property (p_err) else $error("error answer wrong");
endmodule
bind pie_top pie_chk pie_chk_i (.*);

/* File: sim/pie_top_tb.sv */
// bench for the gating block: apb tasks and event scenarios
// assumes the event model and the bound checker
`timescale 1ns/1ps
module pie_top_tb;
   import pie_pkg::*;
   logic clk, rst_b, psel, pen, pwr, prdy, perr, pirq, irq, se, ce;
   logic [7:0] padr;
   logic [31:0] pwd, prd, rv, own2, own3;
   logic [NUM_SRC-1:0] req, ev;
   int fails, checks_done;
   pie_top pie_top_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(ce),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr),
      .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
      .EVENT_IN(ev), .PERIPH_IRQ_OUT(pirq), .IRQ_OUT(irq));
   pie_src_model pie_src_model_i (.clk_in(clk), .rst_b_in(rst_b), .req_in(req), .ev_out(ev));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer, then one idle cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rv = prd;
      se = perr;
      {psel, pen} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, ZERO_WORD);
      chk(n, e, rv);
   endtask
   task automatic fire(input int i);
      req[i] <= 1'b1;
      @(posedge clk);
      req <= '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // core clock and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50us;
      fails++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      {rst_b, psel, pen, pwr, padr, pwd, req} = '0;
      ce = 1'b1;
      fails = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd("enable two", ENABLE_TWO_OFS, ZERO_WORD);
      rd("enable three", ENABLE_THREE_OFS, ZERO_WORD);
      rd("core ctrl", CORE_CTRL_OFS, ZERO_WORD);
      wr(ENABLE_THREE_OFS, 32'hFFFF_FFFF);
      rd("enable three", ENABLE_THREE_OFS, 32'h0000_0010);
      wr(ENABLE_TWO_OFS, 32'hFFFF_FFFF);
      rd("enable two", ENABLE_TWO_OFS, 32'h0000_001F);
      wr(CORE_CTRL_OFS, 32'hFFFF_FFFF);
      rd("core ctrl", CORE_CTRL_OFS, 32'h0000_0040);
      rd("unmapped", 8'h3C, ZERO_WORD);
      chk("unmapped err", 32'h1, 32'(se));
      $display("test registers done");
      for (int i = 0; i < NUM_SRC; i++) begin
         own2 = (i < SRC_CAPCMP_THREE) ? (32'h0000_0010 >> i) : ZERO_WORD;
         own3 = (i == SRC_CAPCMP_THREE) ? 32'h0000_0010 : ZERO_WORD;
         wr(ENABLE_TWO_OFS, 32'h0000_001F ^ own2);
         wr(ENABLE_THREE_OFS, 32'h0000_0010 ^ own3);
         wr(CORE_CTRL_OFS, 32'h0000_0040);
         fire(i);
         rd("flags", FLAG_OFS, 32'h1 << i);
         chk("blocked", 32'h0, 32'(pirq));
         wr(ENABLE_TWO_OFS, own2);
         wr(ENABLE_THREE_OFS, own3);
         chk("passed", 32'h1, 32'(pirq));
         wr(FLAG_OFS, 32'h1 << i);
         chk("cleared", 32'h0, 32'(pirq));
         fire(i);
         chk("event", 32'h1, 32'(pirq));
         wr(CORE_CTRL_OFS, ZERO_WORD);
         chk("no master", 32'h0, 32'(pirq));
         wr(FLAG_OFS, 32'h1 << i);
      end
      $display("test sources done");
      wr(MASK_OFS, ZERO_WORD);
      chk("irq masked", 32'h0, 32'(irq));
      wr(MASK_OFS, 32'h0000_0003);
      chk("irq unmasked", 32'h1, 32'(irq));
      rd("mask", MASK_OFS, 32'h0000_0003);
      rd("status set", STATUS_OFS, 32'h0000_0003);
      chk("mapped err", 32'h0, 32'(se));
      wr(STATUS_OFS, 32'h0000_0003);
      rd("status", STATUS_OFS, ZERO_WORD);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test interrupt done");
      // an event while the clock enable is low must leave no trace
      ce <= 1'b0;
      fire(0);
      ce <= 1'b1;
      rd("frozen flags", FLAG_OFS, ZERO_WORD);
      rd("frozen status", STATUS_OFS, ZERO_WORD);
      $display("test clock enable done");
      wr(ENABLE_TWO_OFS, 32'h0000_001F);
      wr(CORE_CTRL_OFS, 32'h0000_0040);
      wr(ENABLE_THREE_OFS, 32'h0000_0010);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd("enable three", ENABLE_THREE_OFS, ZERO_WORD);
      rd("enable two", ENABLE_TWO_OFS, ZERO_WORD);
      rd("core ctrl", CORE_CTRL_OFS, ZERO_WORD);
      $display("test second reset done");
      complete_run();
   end
endmodule
